// *** domc_defs.svh ***
// register offsets, field positions, reset values and ranges of the dac output mode control
// assumes byte addressing on a 32-bit avalon-mm slave port
`ifndef DOMC_DEFS_SVH
`define DOMC_DEFS_SVH
// ****************************************
// register offsets
// ****************************************
`define DOMC_COMMON_CFG_OFS 4'h0
`define DOMC_DEV_MODE_OFS 4'h1
`define DOMC_VCMP_REGION 4'h1
`define DOMC_IOUT_REGION 4'h2
`define DOMC_CMODE_REGION 4'h3
`define DOMC_DATA_REGION 4'h4
`define DOMC_BYTE_REGION 4'h5
`define DOMC_STAT_REGION 4'h6
// ****************************************
// field positions
// ****************************************
`define DOMC_CPDN_LSB 8
`define DOMC_INTREF_BIT 12
// ****************************************
// encodings and reset values
// ****************************************
`define DOMC_VPDN_UP 2'h0
`define DOMC_VPDN_HIZ 2'h3
`define DOMC_GAIN_EXT 3'h0
`define DOMC_GAIN_VDD 3'h1
`define DOMC_GAIN_X1P5 3'h2
`define DOMC_GAIN_X2 3'h3
`define DOMC_GAIN_X3 3'h4
`define DOMC_GAIN_X4 3'h5
`define DOMC_SUB_INVALID 2'h3
`define DOMC_RES_BITS 12
// current ranges in nA, each symmetric about zero
`define DOMC_RANGE0_NA 32'h0000_61a8
`define DOMC_RANGE1_NA 32'h0000_c350
`define DOMC_RANGE2_NA 32'h0001_e848
`define DOMC_RANGE3_NA 32'h0003_d090
`endif

// *** domc_pkg.sv ***
// types shared by the dac output mode control and its channel and synchroniser modules
// assumes domc_defs.svh sits in the include path
`include "domc_defs.svh"
package domc_pkg;
    typedef enum logic [2:0] {
        DOMC_MODE_OFF = 3'h1,
        DOMC_MODE_VOLT = 3'h2,
        DOMC_MODE_CURR = 3'h4
    } domc_mode_t;

    typedef enum logic [2:0] {
        DOMC_REF_EXT = 3'h1,
        DOMC_REF_VDD = 3'h2,
        DOMC_REF_INT = 3'h4
    } domc_ref_t;

    typedef struct packed {
        logic [1:0] volt_path_powerdown;
        logic curr_path_powerdown;
        logic [2:0] output_gain_select;
        logic comparator_enable;
        logic comparator_drive_type;
        logic comparator_pin_enable;
        logic comparator_invert;
        logic feedback_hiz_disable;
        logic [1:0] current_range_select;
        logic [1:0] comparator_submode;
    } domc_ch_cfg_t;

    typedef struct packed {
        domc_mode_t mode;
        domc_ref_t ref_sel;
        logic int_ref_on;
        logic [3:0] gain_half;
        logic [15:0] vout_num;
        logic signed [31:0] iout_na;
        logic cmp_active;
        logic clip_div6;
        logic submode_ok;
        logic pin_o;
        logic pin_oe;
    } domc_ch_out_t;

    typedef struct packed {
        domc_ch_cfg_t [3:0] ch;
        logic [3:0][11:0] code;
        logic int_ref;
        logic input_mode_disable;
        logic ack;
        logic [31:0] rdata;
    } domc_regs_t;

    localparam domc_ch_cfg_t DOMC_CH_RST = '{
        volt_path_powerdown: `DOMC_VPDN_HIZ,
        curr_path_powerdown: 1'b1,
        output_gain_select: `DOMC_GAIN_EXT,
        default: '0
    };
endpackage

// *** domc_sync.sv ***
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level from outside the clock domain
module domc_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    import domc_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } domc_sync_st_t;

    domc_sync_st_t q, d;

    always_comb
    begin
        d.meta = async_i;
        d.stable = q.meta;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            q <= '0;
        else if (ce)
            q <= d;
    end

    assign sync_o = q.stable;
endmodule

// *** domc_channel.sv ***
// one channel: output mode, reference and gain, transfer values and comparator pin drive
// assumes configuration from the register file and a synchronised comparator result
module domc_channel #(
    parameter int RES = `DOMC_RES_BITS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // settings
    input wire domc_pkg::domc_ch_cfg_t cfg,
    input wire logic [RES-1:0] code,
    input wire logic int_ref_en,
    input wire logic cmp_result,
    // drive towards the analog stage and pin
    output domc_pkg::domc_ch_out_t st
);
    import domc_pkg::*;

    domc_ch_out_t q, d;
    logic [7:0] code8;
    logic [31:0] max_na;
    logic [31:0] prod;
    logic volt_ok;
    logic cmp_val;

    always_comb
    begin
        code8 = code[RES-1:RES-8];
        d = q;
        volt_ok = (cfg.volt_path_powerdown == `DOMC_VPDN_UP) && cfg.curr_path_powerdown;
        if (volt_ok)
            d.mode = DOMC_MODE_VOLT;
        else if (!cfg.curr_path_powerdown && cfg.volt_path_powerdown == `DOMC_VPDN_HIZ)
            d.mode = DOMC_MODE_CURR;
        else
            d.mode = DOMC_MODE_OFF;
        case (cfg.output_gain_select)
            `DOMC_GAIN_VDD:
            begin
                d.ref_sel = DOMC_REF_VDD;
                d.gain_half = 4'h2;
            end
            `DOMC_GAIN_X1P5:
            begin
                d.ref_sel = DOMC_REF_INT;
                d.gain_half = 4'h3;
            end
            `DOMC_GAIN_X2:
            begin
                d.ref_sel = DOMC_REF_INT;
                d.gain_half = 4'h4;
            end
            `DOMC_GAIN_X3:
            begin
                d.ref_sel = DOMC_REF_INT;
                d.gain_half = 4'h6;
            end
            `DOMC_GAIN_X4:
            begin
                d.ref_sel = DOMC_REF_INT;
                d.gain_half = 4'h8;
            end
            default:
            begin
                d.ref_sel = DOMC_REF_EXT;
                d.gain_half = 4'h2;
            end
        endcase
        d.int_ref_on = int_ref_en;
        // vout = vout_num / 2^(RES+1) * vref, gain counted in halves
        d.vout_num = 16'(code) * 16'(d.gain_half);
        case (cfg.current_range_select)
            2'h0: max_na = `DOMC_RANGE0_NA;
            2'h1: max_na = `DOMC_RANGE1_NA;
            2'h2: max_na = `DOMC_RANGE2_NA;
            default: max_na = `DOMC_RANGE3_NA;
        endcase
        prod = 32'(code8) * (max_na << 1);
        d.iout_na = (d.mode == DOMC_MODE_CURR) ? $signed(prod >> 8) - $signed(max_na) : '0;
        d.clip_div6 = !cfg.feedback_hiz_disable && d.gain_half > 4'h4;
        d.submode_ok = cfg.comparator_submode != `DOMC_SUB_INVALID;
        d.cmp_active = cfg.comparator_enable && volt_ok && d.submode_ok;
        cmp_val = cmp_result ^ cfg.comparator_invert;
        d.pin_o = 1'b0;
        d.pin_oe = 1'b0;
        if (d.cmp_active && cfg.comparator_pin_enable)
        begin
            if (cfg.comparator_drive_type)
                d.pin_oe = !cmp_val;
            else
            begin
                d.pin_oe = 1'b1;
                d.pin_o = cmp_val;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.mode <= DOMC_MODE_OFF;
            q.ref_sel <= DOMC_REF_EXT;
        end
        else if (ce)
            q <= d;
    end

    assign st = q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_volt_cfg;
        ce && cfg.volt_path_powerdown == `DOMC_VPDN_UP && cfg.curr_path_powerdown;
    endsequence
    sequence s_pushpull_inv;
        s_volt_cfg ##0 cfg.comparator_enable && cfg.comparator_pin_enable && !cfg.comparator_drive_type
            && cfg.comparator_invert && cfg.comparator_submode != `DOMC_SUB_INVALID;
    endsequence

    property p_volt_mode;
        s_volt_cfg |=> q.mode == DOMC_MODE_VOLT;
    endproperty
    a_volt_mode: assert property (p_volt_mode) else $error("voltage mode not entered");

    property p_curr_mode;
        ce && !cfg.curr_path_powerdown && cfg.volt_path_powerdown == `DOMC_VPDN_HIZ
            |=> q.mode == DOMC_MODE_CURR && q.iout_na == $signed(32'($past(prod) >> 8)) - $signed($past(max_na));
    endproperty
    a_curr_mode: assert property (p_curr_mode) else $error("current mode or value wrong");

    property p_off_mode;
        ce && !(cfg.volt_path_powerdown == `DOMC_VPDN_UP && cfg.curr_path_powerdown)
            && !(!cfg.curr_path_powerdown && cfg.volt_path_powerdown == `DOMC_VPDN_HIZ)
            |=> q.mode == DOMC_MODE_OFF && q.iout_na == 0 && !q.pin_oe;
    endproperty
    a_off_mode: assert property (p_off_mode) else $error("undefined combo not powered down");

    property p_unity_gain;
        ce && (cfg.output_gain_select == `DOMC_GAIN_EXT || cfg.output_gain_select == `DOMC_GAIN_VDD)
            |=> q.gain_half == 4'h2 && q.ref_sel != DOMC_REF_INT;
    endproperty
    a_unity_gain: assert property (p_unity_gain) else $error("non-internal reference not unity");

    property p_cmp_gate;
        ce && !(cfg.comparator_enable && cfg.comparator_pin_enable) |=> !q.pin_oe && !q.pin_o;
    endproperty
    a_cmp_gate: assert property (p_cmp_gate) else $error("pin driven while comparator gated");

    property p_open_drain;
        ce && cfg.comparator_drive_type |=> !q.pin_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain pin drove high");

    property p_invert;
        s_pushpull_inv |=> q.pin_oe && q.pin_o == !$past(cmp_result);
    endproperty
    a_invert: assert property (p_invert) else $error("inverted push-pull value wrong");

    property p_clip;
        ce && !cfg.feedback_hiz_disable
            && (cfg.output_gain_select == `DOMC_GAIN_X3 || cfg.output_gain_select == `DOMC_GAIN_X4)
            |=> q.clip_div6;
    endproperty
    a_clip: assert property (p_clip) else $error("clip divisor not six");

    property p_submode;
        ce && cfg.comparator_submode == `DOMC_SUB_INVALID |=> !q.submode_ok && !q.cmp_active;
    endproperty
    a_submode: assert property (p_submode) else $error("invalid submode accepted");
endmodule

// *** domc_top.sv ***
// dac output mode control: avalon-mm register file and four channel controllers
// assumes one 50 mhz clock, synchronous active-low reset, and async comparator results from the analog side
// Overview of operation
// - voltage mode when voltage path powered up and current path powered down
// - internal reference off after reset, on only when software sets its bit
// - internal reference output is code over 2^N times reference times selected gain
// - external reference is the default and always runs at unity gain
// - supply reference output is code over 2^N times supply, unity gain
// - current mode when current path on and voltage path hi-z
// - each channel current range comes from its range field
// - current equals 8-bit code times signed span over 256 plus minimum
// - comparator works only in voltage mode and only when enabled
// - comparator reaches the pin only when its pin enable is set
// - drive type bit selects push-pull at 0, open-drain at 1
// - inversion bit inverts the comparator output for both drive types
// - feedback input hi-z after reset until software sets disable bit
// - hi-z input clips at reference times gain over 3 or over 6
// - each channel stores its comparator submode; only the invalid check, via submode_ok, reaches the outputs
// - submode 00 normal, 01 hysteresis, 10 window, 11 invalid
module domc_top #(
    parameter int RES = `DOMC_RES_BITS
) (
    // clock, reset and enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // comparator results from the analog side
    input wire logic [3:0] feedback_cmp_result,
    // channel output pins, digital comparator drive
    output logic [3:0] channel_output_pin_o,
    output logic [3:0] channel_output_pin_oe,
    // analog stage settings
    output domc_pkg::domc_ch_out_t [3:0] ch_drive,
    output logic input_mode_disable,
    output logic int_ref_enable
);
    import domc_pkg::*;

    domc_regs_t q, d;
    logic [3:0] cmp_sync;
    logic req;
    logic [3:0] region;
    logic [1:0] chan;
    logic mapped;
    logic writable;
    logic [31:0] rd;
    logic [31:0] wd;

    // ****************************************
    // comparator synchroniser
    // ****************************************
    domc_sync #(
        .W(4)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .async_i(feedback_cmp_result),
        .sync_o(cmp_sync)
    );

    // ****************************************
    // channels
    // ****************************************
    // one independent instance per channel
    for (genvar c = 0; c < 4; c++)
    begin : g_ch
        domc_channel #(
            .RES(RES)
        ) u_ch (
            .clk(clk),
            .rst_b(rst_b),
            .ce(ce),
            .cfg(q.ch[c]),
            .code(q.code[c][RES-1:0]),
            .int_ref_en(q.int_ref),
            .cmp_result(cmp_sync[c]),
            .st(ch_drive[c])
        );
        assign channel_output_pin_o[c] = ch_drive[c].pin_o;
        assign channel_output_pin_oe[c] = ch_drive[c].pin_oe;
    end

    // ****************************************
    // register read mux
    // ****************************************
    always_comb
    begin
        region = avs_address[7:4];
        chan = avs_address[3:2];
        mapped = avs_address[1:0] == 2'h0;
        writable = 1'b1;
        rd = '0;
        if (mapped)
        begin
            case (region)
                4'h0:
                begin
                    if (chan == 2'(`DOMC_COMMON_CFG_OFS))
                    begin
                        for (int i = 0; i < 4; i++)
                        begin
                            rd[2*i +: 2] = q.ch[i].volt_path_powerdown;
                            rd[`DOMC_CPDN_LSB + i] = q.ch[i].curr_path_powerdown;
                        end
                        rd[`DOMC_INTREF_BIT] = q.int_ref;
                    end
                    else if (chan == 2'(`DOMC_DEV_MODE_OFS))
                        rd[0] = q.input_mode_disable;
                    else
                        mapped = 1'b0;
                end
                `DOMC_VCMP_REGION:
                    rd[7:0] = {q.ch[chan].feedback_hiz_disable, q.ch[chan].comparator_invert,
                               q.ch[chan].comparator_pin_enable, q.ch[chan].comparator_drive_type,
                               q.ch[chan].comparator_enable, q.ch[chan].output_gain_select};
                `DOMC_IOUT_REGION:
                    rd[1:0] = q.ch[chan].current_range_select;
                `DOMC_CMODE_REGION:
                    rd[1:0] = q.ch[chan].comparator_submode;
                `DOMC_DATA_REGION:
                    rd[11:0] = q.code[chan];
                `DOMC_BYTE_REGION:
                    rd[7:0] = q.code[chan][RES-1 -: 8];
                `DOMC_STAT_REGION:
                begin
                    // live channel state, read only
                    writable = 1'b0;
                    rd[9:0] = {ch_drive[chan].mode, ch_drive[chan].ref_sel, ch_drive[chan].cmp_active,
                               ch_drive[chan].clip_div6, ch_drive[chan].submode_ok, ch_drive[chan].pin_oe};
                end
                default:
                    mapped = 1'b0;
            endcase
        end
        wd = rd;
        if (avs_byteenable[0])
            wd[7:0] = avs_writedata[7:0];
        if (avs_byteenable[1])
            wd[15:8] = avs_writedata[15:8];
    end

    // ****************************************
    // bus handshake and register update
    // ****************************************
    // one wait cycle per access: data is sampled into rdata, then the write lands with the ack
    always_comb
    begin
        req = avs_read || avs_write;
        d = q;
        d.ack = req && !q.ack;
        if (req && !q.ack)
            d.rdata = mapped ? rd : '0;
        if (avs_write && q.ack && mapped && writable)
        begin
            case (region)
                4'h0:
                begin
                    if (chan == 2'(`DOMC_COMMON_CFG_OFS))
                    begin
                        for (int i = 0; i < 4; i++)
                        begin
                            d.ch[i].volt_path_powerdown = wd[2*i +: 2];
                            d.ch[i].curr_path_powerdown = wd[`DOMC_CPDN_LSB + i];
                        end
                        d.int_ref = wd[`DOMC_INTREF_BIT];
                    end
                    else
                        d.input_mode_disable = wd[0];
                end
                `DOMC_VCMP_REGION:
                begin
                    d.ch[chan].output_gain_select = wd[2:0];
                    d.ch[chan].comparator_enable = wd[3];
                    d.ch[chan].comparator_drive_type = wd[4];
                    d.ch[chan].comparator_pin_enable = wd[5];
                    d.ch[chan].comparator_invert = wd[6];
                    d.ch[chan].feedback_hiz_disable = wd[7];
                end
                `DOMC_IOUT_REGION:
                    d.ch[chan].current_range_select = wd[1:0];
                `DOMC_CMODE_REGION:
                    d.ch[chan].comparator_submode = wd[1:0];
                `DOMC_DATA_REGION:
                    d.code[chan] = 12'(wd[RES-1:0]);
                `DOMC_BYTE_REGION:
                    d.code[chan] = 12'({wd[7:0], {(RES-8){1'b0}}});
                default:
                    d.ack = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.ch <= {4{DOMC_CH_RST}};
        end
        else if (ce)
            q <= d;
    end

    // frozen clock enable keeps the slave stalled, even once the ack is up
    assign avs_waitrequest = req && !(q.ack && ce);
    assign avs_readdata = q.rdata;
    assign input_mode_disable = q.input_mode_disable;
    assign int_ref_enable = q.int_ref;

    // ****************************************
    // assertions
    // ****************************************
    property p_ref_reset;
        @(posedge clk) !rst_b |=> !q.int_ref && q.ch[0].output_gain_select == `DOMC_GAIN_EXT
            && !q.ch[0].feedback_hiz_disable;
    endproperty
    a_ref_reset: assert property (p_ref_reset) else $error("reset defaults wrong");

    property p_wait_bound;
        @(posedge clk) disable iff (!rst_b)
            ce && req && !q.ack ##1 ce && req |-> !avs_waitrequest;
    endproperty
    a_wait_bound: assert property (p_wait_bound) else $error("waitrequest held over one cycle");

    property p_ref_write;
        @(posedge clk) disable iff (!rst_b)
            ce && avs_write && q.ack && avs_address == 8'h00 && avs_byteenable[1]
            |=> q.int_ref == $past(avs_writedata[`DOMC_INTREF_BIT]);
    endproperty
    a_ref_write: assert property (p_ref_write) else $error("reference enable not written");

    // a frozen enable must hold off completion, or the master drops a write that never lands
    property p_ce_stall;
        @(posedge clk) disable iff (!rst_b)
            req && !ce
            |-> avs_waitrequest;
    endproperty
    a_ce_stall: assert property (p_ce_stall) else $error("access completed while enable low");

    property p_ack_pulse;
        @(posedge clk) disable iff (!rst_b)
            ce && q.ack
            |=> !q.ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

    property p_unmapped_read;
        @(posedge clk) disable iff (!rst_b)
            ce && req && !q.ack && !mapped
            |=> avs_readdata == '0;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read gave data");

    property p_status_ro;
        @(posedge clk) disable iff (!rst_b)
            ce && avs_write && q.ack && region == `DOMC_STAT_REGION
            |=> $stable(q.ch) && $stable(q.code) && $stable(q.int_ref);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write changed a setting");

    property p_range_write;
        @(posedge clk) disable iff (!rst_b)
            ce && avs_write && q.ack && mapped && region == `DOMC_IOUT_REGION && avs_byteenable[0]
            |=> q.ch[$past(chan)].current_range_select == $past(avs_writedata[1:0]);
    endproperty
    a_range_write: assert property (p_range_write) else $error("range not stored");

    property p_submode_write;
        @(posedge clk) disable iff (!rst_b)
            ce && avs_write && q.ack && mapped && region == `DOMC_CMODE_REGION && avs_byteenable[0]
            |=> q.ch[$past(chan)].comparator_submode == $past(avs_writedata[1:0]);
    endproperty
    a_submode_write: assert property (p_submode_write) else $error("submode not stored");

    property p_byte_code;
        @(posedge clk) disable iff (!rst_b)
            ce && avs_write && q.ack && mapped && region == `DOMC_BYTE_REGION && avs_byteenable[0]
            |=> q.code[$past(chan)][RES-1 -: 8] == $past(avs_writedata[7:0])
                && q.code[$past(chan)][RES-9:0] == '0;
    endproperty
    a_byte_code: assert property (p_byte_code) else $error("byte code not stored");

    property p_ch_iso;
        @(posedge clk) disable iff (!rst_b)
            ce && avs_write && q.ack && mapped && region == `DOMC_VCMP_REGION && chan == 2'h0
            |=> $stable(q.ch[3:1]);
    endproperty
    a_ch_iso: assert property (p_ch_iso) else $error("write disturbed another channel");
endmodule

// *** tb.sv ***
// self-checking bench for the dac output mode control top
// assumes domc_pkg is compiled first; the bench drives every design input itself except avs_byteenable, which is tied to 4'hf
module tb import domc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, ce, avs_read, avs_write, avs_waitrequest, imd, ire;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] fb, pin_o, pin_oe;
    domc_ch_out_t [3:0] ch_drive;
    int failures, checks_done;
    // ****************************************
    // design and clock
    // ****************************************
    domc_top u_domc_top (.clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .feedback_cmp_result(fb),
        .channel_output_pin_o(pin_o), .channel_output_pin_oe(pin_oe), .ch_drive(ch_drive),
        .input_mode_disable(imd), .int_ref_enable(ire));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // the request stands until a rising edge samples waitrequest low; data are taken at that edge
    task automatic bus_end();
        int i;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (i == 20)
        begin
            failures++;
            conclude();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        bus_end();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        bus(1'b0, 8'h00, 32'h0);
        chk("common", q, 32'h0000_0fff);
        bus(1'b0, 8'h10, 32'h0);
        chk("vcmp0", q, 32'h0);
        chk("mode0", ch_drive[0].mode, DOMC_MODE_OFF);
        chk("iref", ire, 1'b0);
    endtask
    task automatic t_volt();
        logic [3:0] gh [6] = '{4'h2, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
        logic [2:0] rs [6] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h4, 3'h4};
        wr(8'h00, 32'h1ffd);
        wt(2);
        chk("mode0", ch_drive[0].mode, DOMC_MODE_OFF);
        wr(8'h00, 32'h1ffc);
        wr(8'h40, 32'h800);
        wt(2);
        chk("mode0", ch_drive[0].mode, DOMC_MODE_VOLT);
        chk("mode1", ch_drive[1].mode, DOMC_MODE_OFF);
        chk("iref", ire, 1'b1);
        for (int g = 0; g < 6; g++)
        begin
            wr(8'h10, g);
            wt(2);
            chk("gain", ch_drive[0].gain_half, gh[g]);
            chk("ref", ch_drive[0].ref_sel, rs[g]);
            chk("vout", ch_drive[0].vout_num, 16'h0800 * gh[g]);
        end
    endtask
    task automatic t_curr();
        // smallest range before power-on, then code and wanted range
        wr(8'h24, 32'h0);
        wr(8'h00, 32'h1dfc);
        wr(8'h44, 32'hc00);
        wr(8'h24, 32'h1);
        wt(2);
        chk("mode1", ch_drive[1].mode, DOMC_MODE_CURR);
        chk("mode0", ch_drive[0].mode, DOMC_MODE_VOLT);
        chk("iout", ch_drive[1].iout_na, 32'h0000_61a8);
        wr(8'h54, 32'h40);
        wt(2);
        chk("iout", ch_drive[1].iout_na, 32'hffff_9e58);
    endtask
    task automatic t_cmp();
        logic [7:0] cf [7] = '{8'h2b, 8'h6b, 8'h3b, 8'h3b, 8'h7b, 8'h0b, 8'h23};
        logic [2:0] fx [7] = '{3'h7, 3'h5, 3'h4, 3'h1, 3'h5, 3'h4, 3'h4};
        for (int i = 0; i < 7; i++)
        begin
            @(posedge clk);
            fb[0] <= fx[i][2];
            wr(8'h10, cf[i]);
            wt(4);
            chk("oe0", pin_oe[0], fx[i][0]);
            if (fx[i][0])
                chk("o0", pin_o[0], fx[i][1]);
        end
        @(posedge clk);
        fb[1] <= 1'b1;
        wr(8'h14, 32'h2b);
        wt(4);
        chk("oe1", pin_oe[1], 1'b0);
        wr(8'h10, 32'h0c);
        wt(2);
        chk("clip", ch_drive[0].clip_div6, 1'b1);
        wr(8'h10, 32'h0b);
        wt(2);
        chk("clip", ch_drive[0].clip_div6, 1'b0);
        wr(8'h10, 32'h8c);
        wt(2);
        chk("clip", ch_drive[0].clip_div6, 1'b0);
    endtask
    task automatic t_sub();
        @(posedge clk);
        fb[0] <= 1'b1;
        wr(8'h10, 32'h2b);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h30, s);
            wt(4);
            chk("subok", ch_drive[0].submode_ok, s != 3);
            chk("oe0", pin_oe[0], s != 3);
            bus(1'b0, 8'h30, 32'h0);
            chk("sub", q, s);
        end
    endtask
    task automatic t_misc();
        bus(1'b0, 8'h0c, 32'h0);
        chk("unmapped", q, 32'h0);
        bus(1'b0, 8'h02, 32'h0);
        chk("unaligned", q, 32'h0);
        wr(8'h60, 32'hffff);
        bus(1'b0, 8'h60, 32'h0);
        chk("stat0", q, 32'h140);
        wr(8'h04, 32'h1);
        wt(2);
        chk("imd", imd, 1'b1);
    endtask
    task automatic t_ce();
        @(posedge clk);
        avs_write <= 1'b1;
        avs_address <= 8'h04;
        avs_writedata <= 32'h0;
        @(posedge clk);
        ce <= 1'b0;
        wt(2);
        chk("wait_ce", avs_waitrequest, 1'b1);
        chk("imd_ce", imd, 1'b1);
        @(posedge clk);
        ce <= 1'b1;
        bus_end();
        wt(2);
        chk("imd_off", imd, 1'b0);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        failures = 0;
        checks_done = 0;
        rst_b = 1'b0;
        ce = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        fb = 4'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_volt();
        t_curr();
        t_cmp();
        t_sub();
        t_misc();
        t_ce();
        conclude();
    end
endmodule
